// file: pcc_power_control.sv
// Overview of operation
// - Clock output and secondary core enables clear on any reset; rest on power-on only.
// - Power-on loads zeros; oscillator disable set when prescale strap is 11b.
// - Writing loop enable one starts the loop and locks it to 32K reference.
// - Clearing loop enable stops the loop unless it is the system clock.
// - Lock status is read-only, cleared on enable rise, set once locked.
// - Lock status clears on every stop mode entry.
// - Clock output enable routes the undivided core clock onto the shared pin.
// - Unimplemented power control bits 4:3, 9:8, 15:11 read as zero.
// - Reset pin disable frees the pin; otherwise the pin drives reset.
// - In stop mode the regulator stays on only if regulator keep is set.
// - Outside stop mode the regulator is always on.
// - Brownout detection stays active whenever the regulator is on.
// - Stop with brownout disable one and keep zero powers the comparator down.
// - Stop with both bits zero keeps watching supply and raises brownout reset.
// - Secondary core enable clears on reset and stop entry; zero disables the core.
// - Only the supervisory core may read or write the secondary core enable.
// - Writing secondary core enable one releases the processing core to run.
//
// Added by the designer: the AXI4-Lite register port.
`include "pcc_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module pcc_power_control
  import pcc_pkg::*;
(
  // Clock and power-on reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [11:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // AXI4-Lite read
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [11:0] araddr,
  input  wire logic [2:0]  arprot,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // Reset sources
  input  wire logic        sys_reset,
  input  wire logic        reset_pin_n,
  output logic             pin_reset_req,
  output logic             reset_pin_port_free,
  // Frequency-locked loop
  input  wire logic        loop_locked,
  input  wire logic        loop_is_sysclk,
  output logic             loop_run,
  // Oscillator strap
  input  wire logic [1:0]  clock_prescale_select,
  output logic             high_freq_osc_disable,
  // Stop mode and supply
  input  wire logic        stop_mode,
  input  wire logic        vdd_low,
  output logic             regulator_on,
  output logic             brownout_active,
  output logic             brownout_reset,
  // Shared pin and processing core
  output logic             shared_port_clk_sel,
  output logic             processing_core_enable,
  // Interrupt
  output logic             irq
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic [9:0] reg_idx(input logic [11:0] a);
    reg_idx = a[11:2];
  endfunction

  function automatic logic known_idx(input logic [9:0] i);
    known_idx = (i == `PCC_IDX_PWCTL) || (i == `PCC_IDX_IRQ_ST) ||
                (i == `PCC_IDX_IRQ_MSK) || (i == `PCC_IDX_CLKCFG);
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 5'h1_1;
      sync2_r <= 5'h1_1;
    end else begin
      sync1_r <= {clock_prescale_select, vdd_low, loop_locked, reset_pin_n};
      sync2_r <= sync1_r;
    end
  end

  logic       pin_s;
  logic       locked_s;
  logic       vdd_low_s;
  logic [1:0] presc_s;
  assign pin_s     = sync2_r[0];
  assign locked_s  = sync2_r[1];
  assign vdd_low_s = sync2_r[2];
  assign presc_s   = sync2_r[4:3];

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  pcc_ch_e     wst_r;
  logic        aw_got_r;
  logic        w_got_r;
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic [11:0] waddr_r;
  logic        wpriv_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wr_do;

  assign wr_do = (wst_r == PCC_CH_IDLE) && aw_got_r && w_got_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_r     <= PCC_CH_IDLE;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `PCC_OKAY;
      waddr_r   <= 12'h000;
      wpriv_r   <= 1'b0;
      wdata_r   <= `PCC_WORD_RST;
      wstrb_r   <= 4'h0;
    end else begin
      case (wst_r)
        PCC_CH_IDLE: begin
          if (wr_do) begin
            bvalid_r <= 1'b1;
            bresp_r  <= known_idx(reg_idx(waddr_r)) ? `PCC_OKAY : `PCC_SLVERR;
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            wst_r    <= PCC_CH_RESP;
          end else begin
            if (awvalid && awready_r) begin
              aw_got_r  <= 1'b1;
              awready_r <= 1'b0;
              waddr_r   <= awaddr;
              wpriv_r   <= awprot[0];
            end else if (!aw_got_r) begin
              awready_r <= 1'b1;
            end
            if (wvalid && wready_r) begin
              w_got_r  <= 1'b1;
              wready_r <= 1'b0;
              wdata_r  <= wdata;
              wstrb_r  <= wstrb;
            end else if (!w_got_r) begin
              wready_r <= 1'b1;
            end
          end
        end
        PCC_CH_RESP: begin
          if (bready) begin
            bvalid_r <= 1'b0;
            wst_r    <= PCC_CH_IDLE;
          end
        end
        default: wst_r <= PCC_CH_IDLE;
      endcase
    end
  end

  logic [9:0] widx;
  logic       wr_pw;
  assign widx  = reg_idx(waddr_r);
  assign wr_pw = wr_do && (widx == `PCC_IDX_PWCTL);

  // ----------------------------------------
  // Reset sources and stop entry
  // ----------------------------------------
  pcc_pwctl_s pw_r;
  logic       stop_d_r;
  logic       stop_entry;
  logic       pin_rst;
  logic       any_rst;

  assign stop_entry = stop_mode && !stop_d_r;
  assign pin_rst    = !pin_s && !pw_r.reset_pin_disable;
  assign any_rst    = sys_reset || pin_rst;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_d_r <= 1'b0;
    end else begin
      stop_d_r <= stop_mode;
    end
  end

  // ----------------------------------------
  // Power control register
  // ----------------------------------------
  logic loop_en_d_r;
  logic loop_rise;
  logic loop_run_r;
  assign loop_rise = pw_r.loop_enable && !loop_en_d_r;

  // Power-on only bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pw_r.loop_enable           <= 1'b0;
      pw_r.reset_pin_disable     <= 1'b0;
      pw_r.regulator_keep_on     <= 1'b0;
      pw_r.brownout_stop_disable <= 1'b0;
    end else if (wr_pw && wstrb_r[0]) begin
      pw_r.loop_enable           <= wdata_r[`PCC_BIT_LOOP_EN];
      pw_r.reset_pin_disable     <= wdata_r[`PCC_BIT_RSTPIN];
      pw_r.regulator_keep_on     <= wdata_r[`PCC_BIT_REGKEEP];
      pw_r.brownout_stop_disable <= wdata_r[`PCC_BIT_BORDIS];
    end
  end

  // Cleared by every reset kind
  always_ff @(posedge aclk) begin
    if (!aresetn || any_rst) begin
      pw_r.clock_output_enable <= 1'b0;
    end else if (wr_pw && wstrb_r[0]) begin
      pw_r.clock_output_enable <= wdata_r[`PCC_BIT_CLKOUT];
    end
  end

  // Hardware clear beats a same-cycle software set
  always_ff @(posedge aclk) begin
    if (!aresetn || any_rst || stop_entry) begin
      pw_r.secondary_core_enable <= 1'b0;
    end else if (wr_pw && wstrb_r[1] && wpriv_r) begin
      pw_r.secondary_core_enable <= wdata_r[`PCC_BIT_SECCORE];
    end
  end

  // Lock flag never takes bus data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pw_r.loop_lock_status <= 1'b0;
      loop_en_d_r           <= 1'b0;
    end else begin
      loop_en_d_r <= pw_r.loop_enable;
      if (loop_rise || stop_entry) begin
        pw_r.loop_lock_status <= 1'b0;
      end else if (pw_r.loop_enable && loop_run_r && locked_s) begin
        pw_r.loop_lock_status <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pw_r.rsv_hi  <= 5'h00;
      pw_r.rsv_mid <= 2'h0;
      pw_r.rsv_lo  <= 2'h0;
    end else begin
      pw_r.rsv_hi  <= 5'h00;
      pw_r.rsv_mid <= 2'h0;
      pw_r.rsv_lo  <= 2'h0;
    end
  end

  // Loop keeps running while it clocks the system
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_run_r <= 1'b0;
    end else begin
      loop_run_r <= pw_r.loop_enable || (loop_run_r && loop_is_sysclk);
    end
  end

  // ----------------------------------------
  // Oscillator disable, strap caught after reset
  // ----------------------------------------
  logic [2:0] por_dly_r;
  logic       high_freq_osc_disable_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_dly_r <= 3'h0;
      high_freq_osc_disable_r    <= 1'b0;
    end else begin
      por_dly_r <= {por_dly_r[1:0], 1'b1};
      if (!por_dly_r[2]) begin
        high_freq_osc_disable_r <= (presc_s == `PCC_PRESCALE_HIGH_FREQ_OSC_DISABLE);
      end else if (wr_do && widx == `PCC_IDX_CLKCFG && wstrb_r[0]) begin
        high_freq_osc_disable_r <= wdata_r[0];
      end
    end
  end

  // ----------------------------------------
  // Power, pin and core outputs
  // ----------------------------------------
  logic reg_on_r;
  logic bor_act_r;
  logic bor_rst_r;
  logic clk_sel_r;
  logic port_free_r;
  logic pin_req_r;
  logic core_en_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reg_on_r    <= 1'b1;
      bor_act_r   <= 1'b1;
      bor_rst_r   <= 1'b0;
      clk_sel_r   <= 1'b0;
      port_free_r <= 1'b0;
      pin_req_r   <= 1'b0;
      core_en_r   <= 1'b0;
    end else begin
      reg_on_r    <= !stop_mode || pw_r.regulator_keep_on;
      bor_act_r   <= !stop_mode || pw_r.regulator_keep_on ||
                     !pw_r.brownout_stop_disable;
      bor_rst_r   <= bor_act_r && vdd_low_s;
      clk_sel_r   <= pw_r.clock_output_enable;
      port_free_r <= pw_r.reset_pin_disable;
      pin_req_r   <= pin_rst;
      core_en_r   <= pw_r.secondary_core_enable;
    end
  end

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  logic [`PCC_EV_W-1:0] ist_r;
  logic [`PCC_EV_W-1:0] imsk_r;
  logic [`PCC_EV_W-1:0] ev;
  logic                 lock_d_r;
  logic                 bor_d_r;
  logic                 irq_r;

  assign ev = {bor_rst_r && !bor_d_r, pw_r.loop_lock_status && !lock_d_r};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ist_r    <= `PCC_EV_RST;
      imsk_r   <= `PCC_EV_RST;
      lock_d_r <= 1'b0;
      bor_d_r  <= 1'b0;
      irq_r    <= 1'b0;
    end else begin
      lock_d_r <= pw_r.loop_lock_status;
      bor_d_r  <= bor_rst_r;
      irq_r    <= |(ist_r & imsk_r);
      if (wr_do && widx == `PCC_IDX_IRQ_ST && wstrb_r[0]) begin
        ist_r <= (ist_r & ~wdata_r[`PCC_EV_W-1:0]) | ev;
      end else begin
        ist_r <= ist_r | ev;
      end
      if (wr_do && widx == `PCC_IDX_IRQ_MSK && wstrb_r[0]) begin
        imsk_r <= wdata_r[`PCC_EV_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  pcc_ch_e     rst_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [15:0] pw_rd;

  always_comb begin
    pw_rd = pw_r & `PCC_PWCTL_IMPL;
    if (!arprot[0]) begin
      pw_rd[`PCC_BIT_SECCORE] = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_r     <= PCC_CH_IDLE;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= `PCC_WORD_RST;
      rresp_r   <= `PCC_OKAY;
    end else begin
      case (rst_r)
        PCC_CH_IDLE: begin
          if (arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rst_r     <= PCC_CH_RESP;
            rresp_r   <= known_idx(reg_idx(araddr)) ? `PCC_OKAY : `PCC_SLVERR;
            case (reg_idx(araddr))
              `PCC_IDX_PWCTL:   rdata_r <= {16'h0000, pw_rd};
              `PCC_IDX_IRQ_ST:  rdata_r <= {30'h0000_0000, ist_r};
              `PCC_IDX_IRQ_MSK: rdata_r <= {30'h0000_0000, imsk_r};
              `PCC_IDX_CLKCFG:  rdata_r <= {29'h0000_0000, presc_s, high_freq_osc_disable_r};
              default:          rdata_r <= `PCC_WORD_RST;
            endcase
          end else begin
            arready_r <= 1'b1;
          end
        end
        PCC_CH_RESP: begin
          if (rready) begin
            rvalid_r <= 1'b0;
            rst_r    <= PCC_CH_IDLE;
          end
        end
        default: rst_r <= PCC_CH_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Output drive
  // ----------------------------------------
  assign awready                = awready_r;
  assign wready                 = wready_r;
  assign bvalid                 = bvalid_r;
  assign bresp                  = bresp_r;
  assign arready                = arready_r;
  assign rvalid                 = rvalid_r;
  assign rdata                  = rdata_r;
  assign rresp                  = rresp_r;
  assign pin_reset_req          = pin_req_r;
  assign reset_pin_port_free    = port_free_r;
  assign loop_run               = loop_run_r;
  assign high_freq_osc_disable  = high_freq_osc_disable_r;
  assign regulator_on           = reg_on_r;
  assign brownout_active        = bor_act_r;
  assign brownout_reset         = bor_rst_r;
  assign shared_port_clk_sel    = clk_sel_r;
  assign processing_core_enable = core_en_r;
  assign irq                    = irq_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_lock_enable_rise: assert property (loop_rise |=> !pw_r.loop_lock_status)
    else $error("lock status not cleared on enable rise");
  a_lock_stop_clear: assert property (stop_entry |=> !pw_r.loop_lock_status)
    else $error("lock status not cleared on stop entry");
  a_pwctl_rsvd_zero: assert property (arvalid && arready_r &&
                                      reg_idx(araddr) == `PCC_IDX_PWCTL
                                      |=> (rdata_r & ~{16'h0000, `PCC_PWCTL_IMPL}) ==
                                          `PCC_WORD_RST)
    else $error("reserved power control bits read nonzero");
  a_loop_sysclk_hold: assert property (loop_run_r && loop_is_sysclk |=> loop_run_r)
    else $error("loop stopped while it was the system clock");
  a_reg_run_on: assert property (!stop_mode |=> reg_on_r)
    else $error("regulator off outside stop");
  a_reg_stop_off: assert property (stop_mode && !pw_r.regulator_keep_on |=> !reg_on_r)
    else $error("regulator on in stop without keep");
  a_bor_stop_off: assert property (stop_mode && pw_r.brownout_stop_disable &&
                                   !pw_r.regulator_keep_on |=> !bor_act_r)
    else $error("brownout comparator left on in stop");
  a_bor_reg_on: assert property (reg_on_r |-> bor_act_r)
    else $error("brownout off while regulator on");
  a_sec_core_clear: assert property (any_rst || stop_entry
                                     |=> !pw_r.secondary_core_enable ##1 !core_en_r)
    else $error("secondary core not cleared");
  a_clkout_reset: assert property (any_rst |=> ##1 !clk_sel_r)
    else $error("clock output still selected after reset");

endmodule

`default_nettype wire

// file: pcc_consts.svh
`ifndef PCC_CONSTS_SVH
`define PCC_CONSTS_SVH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define PCC_IDX_PWCTL   10'h00F
`define PCC_IDX_IRQ_ST  10'h020
`define PCC_IDX_IRQ_MSK 10'h021
`define PCC_IDX_CLKCFG  10'h022

// ----------------------------------------
// Power control fields and reset values
// ----------------------------------------
`define PCC_BIT_LOOP_EN   0
`define PCC_BIT_LOCK      1
`define PCC_BIT_CLKOUT    2
`define PCC_BIT_RSTPIN    5
`define PCC_BIT_REGKEEP   6
`define PCC_BIT_BORDIS    7
`define PCC_BIT_SECCORE   10
`define PCC_PWCTL_RST     16'h0000
`define PCC_PWCTL_IMPL    16'h04E7
`define PCC_PRESCALE_HIGH_FREQ_OSC_DISABLE 2'b11

// ----------------------------------------
// Interrupt events, bus responses
// ----------------------------------------
`define PCC_EV_LOCK  0
`define PCC_EV_BOR   1
`define PCC_EV_W     2
`define PCC_EV_RST   2'b00
`define PCC_OKAY     2'b00
`define PCC_SLVERR   2'b10
`define PCC_WORD_RST 32'h0000_0000

`endif

// file: pcc_pkg.sv
package pcc_pkg;

  typedef enum logic [1:0] {
    PCC_CH_IDLE = 2'b01,
    PCC_CH_RESP = 2'b10
  } pcc_ch_e;

  typedef struct packed {
    logic [4:0] rsv_hi;
    logic       secondary_core_enable;
    logic [1:0] rsv_mid;
    logic       brownout_stop_disable;
    logic       regulator_keep_on;
    logic       reset_pin_disable;
    logic [1:0] rsv_lo;
    logic       clock_output_enable;
    logic       loop_lock_status;
    logic       loop_enable;
  } pcc_pwctl_s;

endpackage

// file: pcc_power_control_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "pcc_consts.svh"

module pcc_power_control_tb_top
  import pcc_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] d;
    logic [3:0]  s;
    logic        p;
    logic [15:0] exp;
    logic [3:0]  pins;
  } pcc_row_s;

  logic        aclk;
  logic        aresetn;
  logic        awvalid;
  logic        awready;
  logic [11:0] awaddr;
  logic [2:0]  awprot;
  logic        wvalid;
  logic        wready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        bvalid;
  logic        bready;
  logic [1:0]  bresp;
  logic        arvalid;
  logic        arready;
  logic [11:0] araddr;
  logic [2:0]  arprot;
  logic        rvalid;
  logic        rready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        sys_reset;
  logic        reset_pin_n;
  logic        pin_reset_req;
  logic        reset_pin_port_free;
  logic        loop_locked;
  logic        loop_is_sysclk;
  logic        loop_run;
  logic [1:0]  clock_prescale_select;
  logic        high_freq_osc_disable;
  logic        stop_mode;
  logic        vdd_low;
  logic        regulator_on;
  logic        brownout_active;
  logic        brownout_reset;
  logic        shared_port_clk_sel;
  logic        processing_core_enable;
  logic        irq;
  int          err_total;
  int          checked;
  logic [31:0] rd;
  logic [1:0]  rs;
  pcc_pwctl_s  pw;
  pcc_row_s    rows [9];

  pcc_power_control i_pcc_power_control (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .sys_reset(sys_reset), .reset_pin_n(reset_pin_n), .pin_reset_req(pin_reset_req),
    .reset_pin_port_free(reset_pin_port_free), .loop_locked(loop_locked),
    .loop_is_sysclk(loop_is_sysclk), .loop_run(loop_run),
    .clock_prescale_select(clock_prescale_select),
    .high_freq_osc_disable(high_freq_osc_disable), .stop_mode(stop_mode),
    .vdd_low(vdd_low), .regulator_on(regulator_on), .brownout_active(brownout_active),
    .brownout_reset(brownout_reset), .shared_port_clk_sel(shared_port_clk_sel),
    .processing_core_enable(processing_core_enable), .irq(irq)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  // Ready is registered, so its value at the falling edge is what the next rising edge sees
  task automatic axi_wr(input logic [9:0] idx, input logic [31:0] d, input logic [3:0] s,
                        input logic p, output logic [1:0] r);
    int   n  = 0;
    logic ta = 1'b0;
    logic tw = 1'b0;
    logic tb = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= {idx, 2'b00};
    awprot  <= {2'b00, p};
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    bready  <= 1'b1;
    while (!tb && n < 200) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r  = bresp;
      n++;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!tb) chk(32'h0000_0000, 32'h0000_0001, "write hang");
  endtask

  task automatic axi_rd(input logic [9:0] idx, input logic p, output logic [31:0] d,
                        output logic [1:0] r);
    int   n  = 0;
    logic ta = 1'b0;
    logic tr = 1'b0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= {idx, 2'b00};
    arprot  <= {2'b00, p};
    rready  <= 1'b1;
    while (!tr && n < 200) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d  = rdata;
      r  = rresp;
      n++;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!tr) chk(32'h0000_0000, 32'h0000_0001, "read hang");
  endtask

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    close_out();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
    {sys_reset, loop_locked, loop_is_sysclk, stop_mode, vdd_low} = '0;
    reset_pin_n = 1'b1;
    clock_prescale_select = `PCC_PRESCALE_HIGH_FREQ_OSC_DISABLE;
    err_total = 0;
    checked = 0;
    // Row: write data, strobe, prot, readback, {loop, clk out, pin free, core}
    // No serial traffic is driven while the clock output is on
    rows = '{'{16'hFFFF, 4'hF, 1'b1, 16'h04E5, 4'b1111},
             '{16'h0000, 4'hF, 1'b1, 16'h0000, 4'b0000},
             '{16'h0401, 4'hF, 1'b1, 16'h0401, 4'b1001},
             '{16'hFFFF, 4'hF, 1'b0, 16'h00E5, 4'b1111},
             '{16'h0000, 4'hF, 1'b0, 16'h0000, 4'b0001},
             '{16'h0000, 4'hF, 1'b1, 16'h0000, 4'b0000},
             '{16'hFFFF, 4'h1, 1'b1, 16'h00E5, 4'b1110},
             '{16'hFFFF, 4'h2, 1'b1, 16'h04E5, 4'b1111},
             '{16'h0000, 4'h3, 1'b1, 16'h0000, 4'b0000}};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(6);
    chk(high_freq_osc_disable, 1'b1, "osc disable strap");
    chk({regulator_on, brownout_active, irq}, 3'b110, "reset outputs");
    axi_rd(`PCC_IDX_PWCTL, 1'b1, rd, rs);
    chk(rd, `PCC_WORD_RST, "power control reset");
    axi_rd(`PCC_IDX_CLKCFG, 1'b1, rd, rs);
    chk(rd, 32'h0000_0007, "clock config reset");
    foreach (rows[i]) begin
      axi_wr(`PCC_IDX_PWCTL, {16'h0000, rows[i].d}, rows[i].s, rows[i].p, rs);
      chk(rs, `PCC_OKAY, "write resp");
      axi_rd(`PCC_IDX_PWCTL, rows[i].p, rd, rs);
      chk(rd, {16'h0000, rows[i].exp}, "readback");
      @(negedge aclk);
      chk({loop_run, shared_port_clk_sel, reset_pin_port_free, processing_core_enable},
          rows[i].pins, "pins");
    end
    axi_wr(10'h3FF, 32'hFFFF_FFFF, 4'hF, 1'b1, rs);
    chk(rs, `PCC_SLVERR, "unmapped write");
    axi_rd(10'h3FF, 1'b1, rd, rs);
    chk(rs, `PCC_SLVERR, "unmapped read resp");
    chk(rd, 32'h0000_0000, "unmapped read data");
    // Non power-on reset keeps all but clock out and core enable
    axi_wr(`PCC_IDX_PWCTL, 32'h0000_04E5, 4'h3, 1'b1, rs);
    @(posedge aclk);
    sys_reset <= 1'b1;
    @(posedge aclk);
    sys_reset <= 1'b0;
    cyc(3);
    axi_rd(`PCC_IDX_PWCTL, 1'b1, rd, rs);
    chk(rd, 32'h0000_00E1, "sys reset");
    @(posedge aclk);
    reset_pin_n <= 1'b0;
    cyc(6);
    chk(pin_reset_req, 1'b0, "pin ignored");
    axi_wr(`PCC_IDX_PWCTL, 32'h0000_0001, 4'h3, 1'b1, rs);
    cyc(6);
    chk(pin_reset_req, 1'b1, "pin reset");
    @(posedge aclk);
    reset_pin_n <= 1'b1;
    loop_locked <= 1'b1;
    cyc(8);
    axi_rd(`PCC_IDX_PWCTL, 1'b1, rd, rs);
    chk(rd, 32'h0000_0003, "locked");
    axi_rd(`PCC_IDX_IRQ_ST, 1'b1, rd, rs);
    chk(rd, 32'h0000_0001, "lock event");
    chk(irq, 1'b0, "lock event masked");
    axi_wr(`PCC_IDX_IRQ_MSK, 32'h0000_0001, 4'hF, 1'b1, rs);
    cyc(2);
    chk(irq, 1'b1, "irq unmasked");
    axi_wr(`PCC_IDX_IRQ_ST, 32'h0000_0001, 4'hF, 1'b1, rs);
    cyc(2);
    chk(irq, 1'b0, "irq cleared");
    axi_rd(`PCC_IDX_IRQ_ST, 1'b1, rd, rs);
    chk(rd, 32'h0000_0000, "status cleared");
    // Loop must stay on while it clocks the system
    @(posedge aclk);
    loop_is_sysclk <= 1'b1;
    axi_wr(`PCC_IDX_PWCTL, 32'h0000_0000, 4'h3, 1'b1, rs);
    cyc(4);
    chk(loop_run, 1'b1, "loop kept");
    @(posedge aclk);
    loop_is_sysclk <= 1'b0;
    cyc(4);
    chk(loop_run, 1'b0, "loop off");
    axi_wr(`PCC_IDX_PWCTL, 32'h0000_0405, 4'h3, 1'b1, rs);
    cyc(6);
    axi_rd(`PCC_IDX_PWCTL, 1'b1, rd, rs);
    pw = rd[15:0];
    chk(pw.loop_lock_status, 1'b1, "relocked");
    // Lock indication has left the synchroniser before stop, so it cannot relock
    @(posedge aclk);
    loop_locked <= 1'b0;
    cyc(4);
    @(posedge aclk);
    stop_mode <= 1'b1;
    cyc(4);
    axi_rd(`PCC_IDX_PWCTL, 1'b1, rd, rs);
    chk(rd, 32'h0000_0005, "stop entry");
    chk(processing_core_enable, 1'b0, "core off in stop");
    @(posedge aclk);
    stop_mode <= 1'b0;
    // Bit 0 keep, bit 1 brownout disable
    for (int k = 0; k < 4; k++) begin
      axi_wr(`PCC_IDX_PWCTL, {24'h00_0000, k[1], k[0], 6'h00}, 4'h1, 1'b1, rs);
      @(posedge aclk);
      stop_mode <= 1'b1;
      vdd_low <= 1'b1;
      cyc(6);
      chk(regulator_on, k[0], "regulator in stop");
      chk(brownout_active, k[0] | !k[1], "brownout in stop");
      chk(brownout_reset, k[0] | !k[1], "brownout reset");
      @(posedge aclk);
      stop_mode <= 1'b0;
      vdd_low <= 1'b0;
      cyc(4);
      chk({regulator_on, brownout_active}, 2'b11, "run mode supply");
    end
    axi_rd(`PCC_IDX_IRQ_ST, 1'b1, rd, rs);
    chk(rd[`PCC_EV_BOR], 1'b1, "brownout event");
    // Oscillator disable is software owned until the next power-on reset
    axi_wr(`PCC_IDX_CLKCFG, 32'h0000_0000, 4'hF, 1'b1, rs);
    axi_rd(`PCC_IDX_CLKCFG, 1'b1, rd, rs);
    chk(rd, 32'h0000_0006, "osc disable write");
    axi_wr(`PCC_IDX_PWCTL, 32'h0000_04E5, 4'h3, 1'b1, rs);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(6);
    chk(high_freq_osc_disable, 1'b1, "osc disable after power-on");
    chk(processing_core_enable, 1'b0, "core after power-on");
    axi_rd(`PCC_IDX_PWCTL, 1'b1, rd, rs);
    chk(rd, `PCC_WORD_RST, "power control after power-on");
    close_out();
  end

endmodule

`default_nettype wire
